// >>> include/ring_mgr_params.svh
`ifndef RING_MGR_PARAMS_SVH
`define RING_MGR_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define REG_CTRL       8'h00
`define REG_INIT_ADDR  8'h04
`define REG_TX_RING    8'h08
`define REG_RX_RING    8'h0C
`define REG_INDEX      8'h10

// Control register bits
`define CTRL_INIT      0
`define CTRL_START     1
`define CTRL_STOP      2

// Ring pointer layout
`define RING_LEN_MSB   31
`define RING_LEN_LSB   29
`define RING_BASE_MSB  23
`define RING_BASE_LSB  3

// Descriptor word 1 bit positions
`define W1_OWN         15
`define W1_ERR         14
`define W1_FIRST       9
`define W1_LAST        8

// Descriptor geometry, in 16-bit words
`define W_BUF_LOW      2'h0
`define W_STATUS       2'h1
`define W_LENGTH       2'h2
`define W_COUNT        2'h3
`define INIT_LAST_WORD 2'h3

// Reset values
`define RST_LEN_CODE   3'h0
`define RST_BASE       21'h000000
`define RST_INIT_ADDR  24'h000000

`endif

// >>> include/ring_mgr_pkg.sv
`default_nettype none
package ring_mgr_pkg;

	typedef enum logic [7:0] {
		S_IDLE    = 8'h01,
		S_INIT    = 8'h02,
		S_RX_POLL = 8'h04,
		S_RX_LOOK = 8'h08,
		S_RX_CNT  = 8'h10,
		S_RX_STAT = 8'h20,
		S_TX_POLL = 8'h40,
		S_TX_STAT = 8'h80
	} state_e;

	// Status bits 14:8 of receive word 1: summary, framing, overflow, checksum,
	// buffer, first, last
	typedef struct packed {
		state_e        st;
		logic [23:0]   init_addr;
		logic [20:0]   rx_base;
		logic [2:0]    rx_len;
		logic [20:0]   tx_base;
		logic [2:0]    tx_len;
		logic [6:0]    rx_idx;
		logic [6:0]    tx_idx;
		logic [1:0]    wcnt;
		logic          running;
		logic          init_done;
		logic          init_pend;
		logic          poll_tx;
		logic          rx_held;
		logic          rx_first;
		logic          rx_chain_pend;
		logic          rx_end_pend;
		logic          rx_ovf;
		logic          rx_crc;
		logic          rx_odd;
		logic          rx_lb;
		logic [11:0]   rx_cnt;
		logic [6:0]    rx_stat;
		logic [15:0]   rx_lo;
		logic [7:0]    rx_hi;
		logic          rx_abort;
		logic          tx_held;
		logic          tx_in_pkt;
		logic          tx_done_pend;
		logic [15:0]   tx_lo;
		logic [15:0]   tx_w1;
		logic [11:0]   tx_bcnt;
		logic          mem_req;
		logic          mem_we;
		logic [23:0]   mem_addr;
		logic [15:0]   mem_wdata;
		logic          wb_ack;
		logic [31:0]   wb_dat;
	} state_s;

endpackage : ring_mgr_pkg
`default_nettype wire

// >>> rtl/ring_mgr.sv
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ring_mgr_params.svh"

// Function
// - Transmit ring length code in bits 31:29 gives 2^n entries, 1 to 128.
// - Reserved pointer bits 28:24 read as zero; host writes zeros.
// - Ring base sits in bits 23:3; low three address bits are zero.
// - Every ring entry is four consecutive 16-bit words.
// - Separate receive and transmit rings, each polled for buffers.
// - Polling looks no further than the entry after the current one.
// - Ring bases and lengths are read from the initialization block.
// - Writing the start bit lets the device access rings and move packets.
// - Ownership is only handed over; a handed-over entry is never altered.
// - Word 1 bit 15 is ownership; device clears it after filling.
// - Buffer address is word0 15:0 plus word1 7:0; device never changes it.
// - Error summary bit 14 is the OR of framing, overflow, CRC, buffer.
// - Framing bit 13 needs odd bit count and CRC fail; not in loopback.
// - Overflow bit 12 marks data lost to receive FIFO overflow.
// - CRC bit 11 marks a received packet failing its CRC check.
// - Buffer bit 10 when next buffer is not owned while chaining.
// - With a buffer error, overflow is reported only if simultaneous.
// - Start bit 9 on first buffer, end bit 8 on last buffer.
// - Status is written into the entry before it is returned.
// - Receive ring length code in bits 31:29 gives 1 to 128 entries.
// - Message byte count goes to word 3 bits 11:0.
module ring_mgr #(
	parameter logic [2:0] MAX_LEN_CODE = 3'h7
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             mem_req,
	output logic             mem_we,
	output logic      [23:0] mem_addr,
	output logic      [15:0] mem_wdata,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             rx_buf_ok,
	output logic      [23:0] rx_buf_addr,
	output logic             rx_abort,
	input  wire logic        rx_chain_req,
	input  wire logic        rx_end,
	input  wire logic        rx_fifo_ovf,
	input  wire logic        rx_crc_err,
	input  wire logic        rx_odd_bits,
	input  wire logic        rx_int_loop,
	input  wire logic [11:0] rx_byte_count,
	output logic             tx_buf_ok,
	output logic      [23:0] tx_buf_addr,
	output logic      [11:0] tx_buf_len,
	output logic             tx_first,
	output logic             tx_last,
	input  wire logic        tx_done
);

	// Elaboration check: a one-entry cap leaves nothing to look ahead to
	if (MAX_LEN_CODE == 3'h0)
	begin : g_bad_cap
		$error("MAX_LEN_CODE must allow at least two entries");
	end

	ring_mgr_pkg::state_s r;
	ring_mgr_pkg::state_s n;
	logic                 wr_hit;
	logic                 mem_done;
	logic [31:0]          rd_val;
	logic                 frame_err;
	logic [31:0]          tx_img;
	logic [31:0]          rx_img;
	logic                 crc;

	// Index mask for a length code, capped at the largest supported ring
	function automatic logic [6:0] len_mask(input logic [2:0] code);
		logic [2:0] c;
		logic [7:0] t;
		c = (code > MAX_LEN_CODE) ? MAX_LEN_CODE : code;
		t = 8'h01 << c;
		len_mask = 7'(t - 8'h01);
	endfunction : len_mask

	// Byte address of one word of one descriptor
	function automatic logic [23:0] desc_addr(input logic [20:0] base,
		input logic [6:0] idx, input logic [1:0] word);
		desc_addr = {base, 3'h0} + {14'h0, idx, 3'h0} + {21'h0, word, 1'b0};
	endfunction : desc_addr

	// Next ring index with wrap
	function automatic logic [6:0] next_idx(input logic [6:0] idx,
		input logic [2:0] code);
		next_idx = 7'(idx + 7'h01) & len_mask(code);
	endfunction : next_idx

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = sel[i] ? val[i*8 +: 8] : old[i*8 +: 8];
	endfunction : merge

	// Ring pointer image with reserved and low bits zero
	function automatic logic [31:0] ring_ptr(input logic [2:0] len,
		input logic [20:0] base);
		ring_ptr = {len, 5'h00, base, 3'h0};
	endfunction : ring_ptr

	// Register outputs straight from the state record
	assign wb_dat_o    = r.wb_dat;
	assign wb_ack_o    = r.wb_ack;
	assign mem_req     = r.mem_req;
	assign mem_we      = r.mem_we;
	assign mem_addr    = r.mem_addr;
	assign mem_wdata   = r.mem_wdata;
	assign rx_buf_ok   = r.rx_held;
	assign rx_buf_addr = {r.rx_hi, r.rx_lo};
	assign rx_abort    = r.rx_abort;
	assign tx_buf_ok   = r.tx_held;
	assign tx_buf_addr = {r.tx_w1[7:0], r.tx_lo};
	assign tx_buf_len  = r.tx_bcnt;
	assign tx_first    = r.tx_w1[`W1_FIRST];
	assign tx_last     = r.tx_w1[`W1_LAST];

	// Register read view
	always_comb
	begin
		unique case (wb_adr_i)
			`REG_CTRL:      rd_val = {26'h0, r.rx_held, r.tx_held, r.init_pend,
				r.st == ring_mgr_pkg::S_IDLE, r.running, r.init_done};
			`REG_INIT_ADDR: rd_val = {8'h00, r.init_addr};
			`REG_TX_RING:   rd_val = ring_ptr(r.tx_len, r.tx_base);
			`REG_RX_RING:   rd_val = ring_ptr(r.rx_len, r.rx_base);
			`REG_INDEX:     rd_val = {17'h0, r.tx_idx, 1'b0, r.rx_idx};
			default:        rd_val = 32'h0000_0000;
		endcase
	end

	// Next-state logic for bus slave, event latches and ring engine
	always_comb
	begin
		n = r;
		tx_img = merge(ring_ptr(r.tx_len, r.tx_base), wb_dat_i, wb_sel_i);
		rx_img = merge(ring_ptr(r.rx_len, r.rx_base), wb_dat_i, wb_sel_i);
		wr_hit = wb_cyc_i && wb_stb_i && !r.wb_ack;
		mem_done = r.mem_req && mem_ack;
		frame_err = r.rx_odd && r.rx_crc && !r.rx_lb;
		crc = r.rx_crc;
		n.wb_ack = wr_hit;
		n.rx_abort = 1'b0;
		if (wr_hit)
			n.wb_dat = rd_val;
		// Hardware events set their flags; setting wins over handling
		n.rx_chain_pend = r.rx_chain_pend | rx_chain_req;
		n.rx_end_pend = r.rx_end_pend | rx_end;
		n.tx_done_pend = r.tx_done_pend | tx_done;
		if (rx_end)
		begin
			n.rx_ovf = rx_fifo_ovf;
			n.rx_crc = rx_crc_err;
			n.rx_odd = rx_odd_bits;
			n.rx_lb = rx_int_loop;
			n.rx_cnt = rx_byte_count;
		end
		// Register writes
		if (wr_hit && wb_we_i)
		begin
			unique case (wb_adr_i)
				`REG_CTRL:
				begin
					if (wb_sel_i[0] && wb_dat_i[`CTRL_INIT])
						n.init_pend = 1'b1;
					if (wb_sel_i[0] && wb_dat_i[`CTRL_START] && r.init_done)
						n.running = 1'b1;
					if (wb_sel_i[0] && wb_dat_i[`CTRL_STOP])
						n.running = 1'b0;
				end
				`REG_INIT_ADDR: n.init_addr = 24'(merge({8'h00, r.init_addr},
					wb_dat_i, wb_sel_i) & 32'h00FF_FFFE);
				`REG_TX_RING:
				begin
					n.tx_len = tx_img[`RING_LEN_MSB:`RING_LEN_LSB];
					n.tx_base = tx_img[`RING_BASE_MSB:`RING_BASE_LSB];
				end
				`REG_RX_RING:
				begin
					n.rx_len = rx_img[`RING_LEN_MSB:`RING_LEN_LSB];
					n.rx_base = rx_img[`RING_BASE_MSB:`RING_BASE_LSB];
				end
				default:
				begin
				end
			endcase
		end
		// Ring engine; one memory access at a time
		unique case (r.st)
			ring_mgr_pkg::S_IDLE:
			begin
				n.wcnt = 2'h0;
				if (r.init_pend && !r.running)
				begin
					n.init_pend = 1'b0;
					n.init_done = 1'b0;
					n.st = ring_mgr_pkg::S_INIT;
				end
				else if (r.running && r.rx_held && r.rx_end_pend)
				begin
					n.rx_end_pend = rx_end;
					n.rx_stat = {r.rx_ovf | frame_err | crc, frame_err & !r.rx_ovf,
						r.rx_ovf, crc & !r.rx_ovf, 1'b0, r.rx_first,
						!r.rx_ovf};
					n.st = r.rx_ovf ? ring_mgr_pkg::S_RX_STAT
						: ring_mgr_pkg::S_RX_CNT;
				end
				else if (r.running && r.rx_held && r.rx_chain_pend)
				begin
					n.rx_chain_pend = rx_chain_req;
					n.st = ring_mgr_pkg::S_RX_LOOK;
				end
				else if (r.running && r.tx_held && r.tx_done_pend)
				begin
					n.tx_done_pend = tx_done;
					n.st = ring_mgr_pkg::S_TX_STAT;
				end
				else if (r.running && !r.rx_held && (!r.poll_tx || r.tx_held))
				begin
					n.poll_tx = 1'b1;
					n.st = ring_mgr_pkg::S_RX_POLL;
				end
				else if (r.running && !r.tx_held)
				begin
					n.poll_tx = 1'b0;
					n.st = ring_mgr_pkg::S_TX_POLL;
				end
			end
			ring_mgr_pkg::S_INIT:
			begin
				if (!r.mem_req)
				begin
					n.mem_req = 1'b1;
					n.mem_we = 1'b0;
					n.mem_addr = r.init_addr + {21'h0, r.wcnt, 1'b0};
				end
				else if (mem_done)
				begin
					n.mem_req = 1'b0;
					n.wcnt = 2'(r.wcnt + 2'h1);
					unique case (r.wcnt)
						2'h0: n.rx_base[12:0] = mem_rdata[15:3];
						2'h1: {n.rx_len, n.rx_base[20:13]} = {mem_rdata[15:13],
							mem_rdata[7:0]};
						2'h2: n.tx_base[12:0] = mem_rdata[15:3];
						2'h3: {n.tx_len, n.tx_base[20:13]} = {mem_rdata[15:13],
							mem_rdata[7:0]};
					endcase
					if (r.wcnt == `INIT_LAST_WORD)
					begin
						n.init_done = 1'b1;
						n.rx_idx = 7'h00;
						n.tx_idx = 7'h00;
						n.rx_held = 1'b0;
						n.tx_held = 1'b0;
						n.rx_first = 1'b1;
						n.tx_in_pkt = 1'b0;
						n.st = ring_mgr_pkg::S_IDLE;
					end
				end
			end
			ring_mgr_pkg::S_RX_POLL:
			begin
				if (!r.mem_req)
				begin
					n.mem_req = 1'b1;
					n.mem_we = 1'b0;
					n.mem_addr = desc_addr(r.rx_base, r.rx_idx, r.wcnt);
				end
				else if (mem_done)
				begin
					n.mem_req = 1'b0;
					n.wcnt = 2'(r.wcnt + 2'h1);
					if (r.wcnt == `W_BUF_LOW)
						n.rx_lo = mem_rdata;
					else
					begin
						n.rx_hi = mem_rdata[7:0];
						n.rx_held = mem_rdata[`W1_OWN];
						n.st = ring_mgr_pkg::S_IDLE;
					end
				end
			end
			ring_mgr_pkg::S_RX_LOOK:
			begin
				if (!r.mem_req)
				begin
					n.mem_req = 1'b1;
					n.mem_we = 1'b0;
					n.mem_addr = desc_addr(r.rx_base, next_idx(r.rx_idx, r.rx_len),
						`W_STATUS);
				end
				else if (mem_done)
				begin
					n.mem_req = 1'b0;
					if (mem_rdata[`W1_OWN] && !rx_fifo_ovf)
						n.rx_stat = {5'h00, r.rx_first, 1'b0};
					else
						n.rx_stat = {2'b10, rx_fifo_ovf, 1'b0, 1'b1, r.rx_first,
							1'b0};
					n.st = ring_mgr_pkg::S_RX_STAT;
				end
			end
			ring_mgr_pkg::S_RX_CNT:
			begin
				if (!r.mem_req)
				begin
					n.mem_req = 1'b1;
					n.mem_we = 1'b1;
					n.mem_addr = desc_addr(r.rx_base, r.rx_idx, `W_COUNT);
					n.mem_wdata = {4'h0, r.rx_cnt};
				end
				else if (mem_done)
				begin
					n.mem_req = 1'b0;
					n.st = ring_mgr_pkg::S_RX_STAT;
				end
			end
			ring_mgr_pkg::S_RX_STAT:
			begin
				if (!r.mem_req)
				begin
					n.mem_req = 1'b1;
					n.mem_we = 1'b1;
					n.mem_addr = desc_addr(r.rx_base, r.rx_idx, `W_STATUS);
					n.mem_wdata = {1'b0, r.rx_stat, r.rx_hi};
				end
				else if (mem_done)
				begin
					n.mem_req = 1'b0;
					n.rx_held = 1'b0;
					n.rx_idx = next_idx(r.rx_idx, r.rx_len);
					n.rx_first = r.rx_stat[0] | r.rx_stat[2] | r.rx_stat[4];
					n.rx_abort = r.rx_stat[2] | r.rx_stat[4];
					n.st = ring_mgr_pkg::S_IDLE;
				end
			end
			ring_mgr_pkg::S_TX_POLL:
			begin
				if (!r.mem_req)
				begin
					n.mem_req = 1'b1;
					n.mem_we = 1'b0;
					n.mem_addr = desc_addr(r.tx_base, r.tx_idx, r.wcnt);
				end
				else if (mem_done)
				begin
					n.mem_req = 1'b0;
					n.wcnt = 2'(r.wcnt + 2'h1);
					unique case (r.wcnt)
						`W_BUF_LOW: n.tx_lo = mem_rdata;
						`W_STATUS:
						begin
							n.tx_w1 = mem_rdata;
							if (!mem_rdata[`W1_OWN])
								n.st = ring_mgr_pkg::S_IDLE;
							else if (!mem_rdata[`W1_FIRST] && !r.tx_in_pkt)
							begin
								n.tx_idx = next_idx(r.tx_idx, r.tx_len);
								n.st = ring_mgr_pkg::S_IDLE;
							end
						end
						default:
						begin
							n.tx_bcnt = mem_rdata[11:0];
							n.tx_held = 1'b1;
							n.tx_in_pkt = 1'b1;
							n.st = ring_mgr_pkg::S_IDLE;
						end
					endcase
				end
			end
			ring_mgr_pkg::S_TX_STAT:
			begin
				if (!r.mem_req)
				begin
					n.mem_req = 1'b1;
					n.mem_we = 1'b1;
					n.mem_addr = desc_addr(r.tx_base, r.tx_idx, `W_STATUS);
					n.mem_wdata = {1'b0, r.tx_w1[14:0]};
				end
				else if (mem_done)
				begin
					n.mem_req = 1'b0;
					n.tx_held = 1'b0;
					n.tx_in_pkt = !r.tx_w1[`W1_LAST];
					n.tx_idx = next_idx(r.tx_idx, r.tx_len);
					n.st = ring_mgr_pkg::S_IDLE;
				end
			end
		endcase
		// Stopping releases both held buffers without touching memory
		if (!n.running)
		begin
			n.rx_held = (r.st == ring_mgr_pkg::S_RX_POLL) ? n.rx_held : 1'b0;
			n.tx_held = (r.st == ring_mgr_pkg::S_TX_POLL) ? n.tx_held : 1'b0;
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.st <= ring_mgr_pkg::S_IDLE;
			r.rx_len <= `RST_LEN_CODE;
			r.tx_len <= `RST_LEN_CODE;
			r.rx_base <= `RST_BASE;
			r.tx_base <= `RST_BASE;
			r.init_addr <= `RST_INIT_ADDR;
			r.rx_first <= 1'b1;
		end
		else if (ce)
			r <= n;
	end

endmodule : ring_mgr
`default_nettype wire

// >>> bench/host_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Host memory shared with the ring manager; answers after 1 to 4 cycles
module host_mem (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [23:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic      [15:0] mem_rdata,
	output logic             mem_ack
);
	logic [15:0] mem [0:2047];
	int          wait_n;

	// Serve a request when the wait runs out; idle data toggles so stale reads show
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			mem_ack   <= 1'b0;
			mem_rdata <= 16'h0000;
			wait_n    <= 0;
		end
		else if (mem_req && mem_ack)
		begin
			if (mem_we)
				mem[mem_addr[11:1]] <= mem_wdata;
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_n    <= slow ? $urandom_range(3, 0) : 0;
		end
		else if (mem_req && wait_n == 0)
		begin
			mem_ack   <= 1'b1;
			mem_rdata <= mem[mem_addr[11:1]];
		end
		else
		begin
			wait_n    <= (mem_req && wait_n > 0) ? wait_n - 1 : wait_n;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : host_mem
`default_nettype wire

// >>> bench/ring_mgr_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "ring_mgr_params.svh"
// Bus and descriptor write checks at the ring manager ports
module ring_mgr_checker (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic        mem_ack,
	input wire logic        rx_buf_ok,
	input wire logic        rx_abort
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// Bus request taken, and a word 1 write-back on the memory port
	sequence s_wb_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	endsequence
	sequence s_w1_write;
		mem_req && mem_we && mem_addr[2:1] == 2'h1;
	endsequence

	a_ack_next: assert property (s_wb_take |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	a_rsvd_zero: assert property (
		wb_ack_o && $past(!wb_we_i && wb_adr_i == `REG_TX_RING)
		|-> wb_dat_o[28:24] == 5'h00 && wb_dat_o[2:0] == 3'h0)
		else $error("reserved pointer bits read nonzero");
	a_mem_hold: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
		&& $stable(mem_wdata))
		else $error("memory request changed before ack");
	a_mem_drop: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("memory request held after ack");
	a_word_only: assert property (
		mem_req |-> !mem_addr[0] && (!mem_we || mem_addr[1]))
		else $error("device wrote word 0 or 2 or odd address");
	a_own_return: assert property (s_w1_write |-> !mem_wdata[15])
		else $error("word 1 written with ownership set");
	a_err_summary: assert property (
		s_w1_write |-> mem_wdata[14] == |mem_wdata[13:10])
		else $error("error summary differs from flags");
	a_frame_crc: assert property (s_w1_write |-> !mem_wdata[13] || mem_wdata[11])
		else $error("framing flag without checksum flag");
	a_abort_pulse: assert property (rx_abort |=> !rx_abort)
		else $error("abort longer than one cycle");
	a_hold_owned: assert property (
		$rose(rx_buf_ok) |-> $past(mem_ack && !mem_we && mem_rdata[15])
		|| $past(mem_ack && !mem_we && mem_rdata[15], 2))
		else $error("buffer held without owned read");
endmodule : ring_mgr_checker

bind ring_mgr ring_mgr_checker chk (.mclk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .mem_req, .mem_we, .mem_addr, .mem_wdata,
	.mem_rdata, .mem_ack, .rx_buf_ok, .rx_abort);
`default_nettype wire

// >>> bench/ring_mgr_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ring_mgr_params.svh"
module ring_mgr_tb;
	logic        mclk, rst, ce, slow, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, v;
	logic        mem_req, mem_we, mem_ack, rx_buf_ok, rx_abort, rx_chain_req, rx_end;
	logic        rx_fifo_ovf, rx_crc_err, rx_odd_bits, rx_int_loop;
	logic        tx_buf_ok, tx_first, tx_last, tx_done;
	logic [23:0] mem_addr, rx_buf_addr, tx_buf_addr;
	logic [15:0] mem_wdata, mem_rdata;
	logic [11:0] rx_byte_count, tx_buf_len;
	logic [23:0] ba [2];
	int          mismatches, checks_done, n, k;

	ring_mgr uut (.mclk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .rx_buf_ok, .rx_buf_addr, .rx_abort, .rx_chain_req, .rx_end,
		.rx_fifo_ovf, .rx_crc_err, .rx_odd_bits, .rx_int_loop, .rx_byte_count, .tx_buf_ok,
		.tx_buf_addr, .tx_buf_len, .tx_first, .tx_last, .tx_done);
	host_mem host (.mclk, .rst, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack);

	// 20 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// One classic bus cycle, read data kept in q
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (n = 0; n < 100; n++)
		begin
			@(posedge mclk);
			if (wb_ack_o === 1'b1)
				break;
		end
		// A bus cycle that is never answered counts as a mismatch
		if (wb_ack_o !== 1'b1)
			mismatches++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	// Expected word 1: flags {framing,overflow,checksum,buffer,first,last}, summary derived
	function automatic logic [15:0] st(input logic [5:0] f, input logic [7:0] h);
		return {1'b0, |f[5:2], f, h};
	endfunction : st

	task wait_back(input int idx);
		for (n = 0; n < 3000 && host.mem[idx][15] !== 1'b0; n++)
			@(negedge mclk);
		check(host.mem[idx][15], 1'b0);
	endtask : wait_back

	task wait_hold(input int i);
		for (n = 0; n < 3000 && !(rx_buf_ok === 1'b1 && rx_buf_addr === ba[i]); n++)
			@(negedge mclk);
		check(rx_buf_ok, 1'b1);
		check(rx_buf_addr, ba[i]);
	endtask : wait_hold

	task wait_abort();
		for (n = 0; n < 3000 && rx_abort !== 1'b1; n++)
			@(negedge mclk);
		check(rx_abort, 1'b1);
	endtask : wait_abort

	// Host hands receive entry i to the device with its buffer address
	task give(input int i);
		@(negedge mclk);
		host.mem[16'h100 + 4 * i] = ba[i][15:0];
		host.mem[16'h103 + 4 * i] = 16'hAAAA;
		host.mem[16'h101 + 4 * i] = {8'h80, ba[i][23:16]};
	endtask : give

	task rx_pulse(input logic chain, input logic ovf, input logic crc, input logic odd);
		@(posedge mclk);
		rx_chain_req  <= chain;
		rx_end        <= !chain;
		rx_fifo_ovf   <= ovf;
		rx_crc_err    <= crc;
		rx_odd_bits   <= odd;
		rx_byte_count <= 12'($urandom);
		@(posedge mclk);
		rx_chain_req <= 1'b0;
		rx_end       <= 1'b0;
	endtask : rx_pulse

	// Watchdog
	initial
	begin
		repeat (50000) @(posedge mclk);
		mismatches++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		{rst, ce, wb_sel_i} = 6'h3F;
		{slow, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, tx_done} = '0;
		{rx_chain_req, rx_end, rx_fifo_ovf, rx_crc_err, rx_odd_bits, rx_int_loop} = '0;
		rx_byte_count = 12'h000;
		void'($urandom(58));
		ba[0] = 24'($urandom);
		ba[1] = 24'($urandom);
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		v = $urandom;
		wb(1'b1, `REG_TX_RING, v);
		wb(1'b0, `REG_TX_RING, 32'h0);
		check(q, v & 32'hE0FF_FFF8);
		wb(1'b0, 8'h40, 32'h0);
		check(q, 32'h0);
		$display("test regs done");
		// Init block, two-entry receive ring and two-entry transmit ring
		host.mem[16'h080] = 16'h0200;
		host.mem[16'h081] = 16'h2000;
		host.mem[16'h082] = 16'h0400;
		host.mem[16'h083] = 16'h2000;
		host.mem[16'h200] = 16'h1111;
		host.mem[16'h201] = 16'h8122;
		host.mem[16'h204] = 16'h3344;
		host.mem[16'h205] = 16'h8355;
		host.mem[16'h206] = 16'hF9C4;
		give(0);
		give(1);
		wb(1'b1, `REG_INIT_ADDR, 32'h100);
		wb(1'b1, `REG_CTRL, 32'h1 << `CTRL_INIT);
		q = 32'h0;
		for (k = 0; k < 50 && q[0] !== 1'b1; k++)
			wb(1'b0, `REG_CTRL, 32'h0);
		wb(1'b0, `REG_RX_RING, 32'h0);
		check(q, 32'h2000_0200);
		wb(1'b0, `REG_TX_RING, 32'h0);
		check(q, 32'h2000_0400);
		$display("test init done");
		slow <= 1'b1;
		wb(1'b1, `REG_CTRL, 32'h1 << `CTRL_START);
		for (n = 0; n < 3000 && tx_buf_ok !== 1'b1; n++)
			@(negedge mclk);
		check(tx_buf_ok, 1'b1);
		check(tx_buf_addr, 24'h553344);
		check({tx_first, tx_last, tx_buf_len}, 14'h39C4);
		@(posedge mclk) tx_done <= 1'b1;
		@(posedge mclk) tx_done <= 1'b0;
		wait_back(16'h205);
		check(host.mem[16'h205], 16'h0355);
		check(host.mem[16'h201], 16'h8122);
		$display("test tx done");
		wait_hold(0);
		v = $urandom;
		@(posedge mclk) rx_int_loop <= v[2];
		rx_pulse(1'b0, 1'b0, v[0], v[1]);
		wait_back(16'h101);
		check(host.mem[16'h103], {4'h0, rx_byte_count});
		check(host.mem[16'h101], st({v[0] & v[1] & !v[2], 1'b0, v[0], 3'b011}, ba[0][23:16]));
		give(0);
		wait_hold(1);
		$display("test single done");
		rx_pulse(1'b1, 1'b0, 1'b0, 1'b0);
		wait_back(16'h105);
		check(host.mem[16'h105], st(6'b000010, ba[1][23:16]));
		wait_hold(0);
		rx_pulse(1'b0, 1'b0, 1'b0, 1'b1);
		wait_back(16'h101);
		check(host.mem[16'h101], st(6'b000001, ba[0][23:16]));
		$display("test chain done");
		give(1);
		wait_hold(1);
		rx_pulse(1'b1, 1'b0, 1'b0, 1'b0);
		wait_abort();
		check(host.mem[16'h105], st(6'b000110, ba[1][23:16]));
		$display("test buffer error done");
		give(0);
		wait_hold(0);
		rx_pulse(1'b0, 1'b1, 1'b0, 1'b0);
		wait_abort();
		check(host.mem[16'h101][15:12], 4'h5);
		check(host.mem[16'h103], 16'hAAAA);
		@(posedge mclk) rx_fifo_ovf <= 1'b0;
		$display("test overflow done");
		stop_test();
	end
endmodule : ring_mgr_tb
`default_nettype wire
